// >>> verilog/background_debug_command_unit.sv
// Background debug command unit: command register, status, map control and lockout
//
// Summary of operation
// - Firmware commands run only in background mode
// - Active mode maps debug ROM and registers
// - In-map hardware commands map only during access
// - Decode read opcodes 62 to 67
// - Decode write opcodes 42 to 47
// - Decode resume, single step, tag and resume
// - Opcode byte first, then address and data
// - Every read returns sixteen data bits
// - Hold buses; freeze CPU for multi-cycle access
// - Lockout blocks background mode and debug ROM
// - No-lockout bit loaded at reset, special-mode writes
// - Erased shadow byte unlocks at next reset
// - Lockout blocks reset-vector start in special single-chip
// - Status write permissions depend on hardware flag
// - Status reset value depends on mode
// - Permit bit gates background entry only
// - Active bit set on entry; clear delayed four cycles
// - Command register clears after 512 idle cycles
// - Clock select bit; slow E clock forced
`timescale 1ns/1ps
module background_debug_command_unit #(
  parameter int TIMEOUT = bdm_pkg::TIMEOUT_CYC,
  parameter int WAIT    = bdm_pkg::STEAL_WAIT
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Serial pin and shifter
  input  wire logic             debug_serial_pin_i,
  input  wire logic             op_valid_i,
  input  wire logic [7:0]       op_i,
  input  wire logic             word_valid_i,
  input  wire logic [15:0]      word_i,
  input  wire logic             addr_phase_i,
  // Hardware memory access
  input  wire logic             hw_req_i,
  input  wire logic             cpu_free_i,
  input  wire logic             multi_i,
  input  wire logic             access_done_i,
  output logic                  grant_o,
  output logic                  freeze_cpu_o,
  // Internal CPU bus to debug registers
  input  wire bdm_pkg::bus_req_s bus_i,
  output logic [7:0]            bus_rdata_o,
  output logic                  reg_hit_o,
  output logic                  rom_select_o,
  // Background mode control
  input  wire logic             bkgnd_req_i,
  input  wire logic             instr_boundary_i,
  input  wire logic             step_done_i,
  output logic                  background_debug_state_o,
  output logic                  entry_refused_o,
  // Firmware command hand-off
  output logic                  fw_cmd_valid_o,
  output bdm_pkg::fw_cmd_s      fw_cmd_o,
  output logic [15:0]           read_word_o,
  // Modes, lockout and clocks
  input  wire logic             special_mode_pin_n,
  input  wire logic             single_chip_i,
  input  wire logic             peripheral_i,
  input  wire logic             nvm_shadow_nolock_i,
  input  wire logic             nolock_wr_i,
  input  wire logic             nolock_wdata_i,
  input  wire logic             e_slower_i,
  output logic                  use_e_clock_o,
  output logic                  lockout_o,
  output logic                  reset_vector_block_o
);

  localparam int TW = $clog2(TIMEOUT + 1);

  // Registers
  logic [7:0]  instr_q;
  logic [7:0]  status_q;
  logic [15:0] shift_q;
  logic [15:0] ptr_q;
  logic [7:0]  ccr_q;
  logic        no_lockout_q;
  logic [2:0]  init_q;
  localparam int ACT_W = bdm_pkg::ACT_CLR_DELAY;
  logic [ACT_W-1:0] clr_pipe_q;
  logic [TW-1:0] idle_q;
  logic [1:0]  pin_sync_q;
  logic        pin_prev_q;
  logic [1:0]  smode_sync_q;
  logic [7:0]  rdata_q;

  // Pin synchronisers; only the second stage is read
  // Idle-high reset levels keep a false edge from following reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sync_q   <= 2'h3;
      smode_sync_q <= 2'h3;
      pin_prev_q   <= 1'b1;
    end else begin
      pin_sync_q   <= {pin_sync_q[0], debug_serial_pin_i};
      smode_sync_q <= {smode_sync_q[0], special_mode_pin_n};
      pin_prev_q   <= pin_sync_q[1];
    end
  end

  logic host_fall_w;
  logic special_w;
  logic timeout_w;

  assign host_fall_w = pin_prev_q && !pin_sync_q[1];
  assign special_w   = !smode_sync_q[1];
  assign timeout_w   = (idle_q == TW'(TIMEOUT));

  // Idle counter between host falling edges
  // Any host falling edge restarts the count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_q <= '0;
    end else if (host_fall_w || timeout_w) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // Lockout and map decisions
  // Lockout overrides the status bit, so the ROM never maps
  logic lockout_w;
  logic active_w;
  logic hit_any_w;
  logic map_w;
  logic in_regs_w;
  logic in_rom_w;

  assign lockout_w = !no_lockout_q;
  assign active_w  = status_q[bdm_pkg::ST_ACTIVE] && !lockout_w;
  assign map_w     = active_w
                   || (grant_o && instr_q[bdm_pkg::INS_HW] && instr_q[bdm_pkg::INS_MAP]
                       && !lockout_w);
  assign in_regs_w = (bus_i.addr >= bdm_pkg::ADDR_INSTR) && (bus_i.addr <= bdm_pkg::ADDR_CCR);
  assign in_rom_w  = (bus_i.addr >= bdm_pkg::ROM_LO) && (bus_i.addr <= bdm_pkg::ROM_HI);
  assign hit_any_w = map_w && in_regs_w;
  assign reg_hit_o    = hit_any_w;
  assign rom_select_o = map_w && in_rom_w;
  assign lockout_o    = lockout_w;
  assign reset_vector_block_o = lockout_w && special_w && single_chip_i;
  assign background_debug_state_o = active_w;

  // Register write strobes
  logic wr_instr_w;
  logic wr_status_w;
  logic wr_shi_w;
  logic wr_slo_w;
  logic wr_ccr_w;

  assign wr_instr_w  = hit_any_w && bus_i.wr && (bus_i.addr == bdm_pkg::ADDR_INSTR);
  assign wr_status_w = hit_any_w && bus_i.wr && (bus_i.addr == bdm_pkg::ADDR_STATUS);
  assign wr_shi_w    = hit_any_w && bus_i.wr && (bus_i.addr == bdm_pkg::ADDR_SHIFT_HI);
  assign wr_slo_w    = hit_any_w && bus_i.wr && (bus_i.addr == bdm_pkg::ADDR_SHIFT_LO);
  assign wr_ccr_w    = hit_any_w && bus_i.wr && (bus_i.addr == bdm_pkg::ADDR_CCR);

  // Command register: loaded by the shifter, by the bus, cleared on time-out
  // Time-out comes first, so a stalled host leaves no stale command
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_q <= 8'h00;
    end else if (timeout_w) begin
      instr_q <= 8'h00;
    end else if (op_valid_i && !status_q[bdm_pkg::ST_TAG]) begin
      instr_q <= op_i;
    end else if (wr_instr_w) begin
      instr_q <= bus_i.wdata;
    end
  end

  // Status write mask follows the hardware flag of the command register
  // Active bit is for firmware, clock select for the host
  logic [7:0] st_mask_w;
  assign st_mask_w = bdm_pkg::ST_WR_ALWAYS
                   | (instr_q[bdm_pkg::INS_HW] ? (8'h01 << bdm_pkg::ST_CLKSEL)
                                               : (8'h01 << bdm_pkg::ST_ACTIVE));

  // Entry to background mode, refused unless permitted and unlocked
  // A request waits in pend_entry_q for an instruction boundary
  logic entry_w;
  logic want_entry_w;
  logic pend_entry_q;
  assign want_entry_w = bkgnd_req_i || pend_entry_q;
  assign entry_w = want_entry_w && instr_boundary_i && status_q[bdm_pkg::ST_PERMIT]
                 && !lockout_w && !status_q[bdm_pkg::ST_ACTIVE];
  assign entry_refused_o = bkgnd_req_i && (!status_q[bdm_pkg::ST_PERMIT] || lockout_w);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_entry_q <= 1'b0;
    end else begin
      pend_entry_q <= want_entry_w && !entry_w && !entry_refused_o;
    end
  end

  // Active-bit clear pipeline: a written zero lands four cycles later
  // The delay lets the exit store retire before the ROM unmaps
  logic clr_req_w;
  assign clr_req_w = wr_status_w && st_mask_w[bdm_pkg::ST_ACTIVE]
                   && !bus_i.wdata[bdm_pkg::ST_ACTIVE];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_pipe_q <= '0;
    end else begin
      clr_pipe_q <= {clr_pipe_q[ACT_W-2:0], clr_req_w};
    end
  end

  // Next status value; hardware sets win over software clears
  // Later lines override earlier ones within one cycle
  logic [7:0] st_d;
  logic       step_w;
  logic       tag_go_w;

  assign step_w   = fw_cmd_valid_o && fw_cmd_o.step;
  assign tag_go_w = fw_cmd_valid_o && fw_cmd_o.tag;

  always_comb begin
    st_d = status_q;
    if (wr_status_w) begin
      st_d = (status_q & ~st_mask_w) | (bus_i.wdata & st_mask_w);
      st_d[bdm_pkg::ST_ACTIVE] = status_q[bdm_pkg::ST_ACTIVE]
                               | (bus_i.wdata[bdm_pkg::ST_ACTIVE] & st_mask_w[bdm_pkg::ST_ACTIVE]);
    end
    if (clr_pipe_q[ACT_W-1]) st_d[bdm_pkg::ST_ACTIVE] = 1'b0;
    if (step_done_i) st_d[bdm_pkg::ST_TRACE] = 1'b0;
    if (step_w) st_d[bdm_pkg::ST_TRACE] = 1'b1;
    if (tag_go_w) st_d[bdm_pkg::ST_TAG] = 1'b1;
    if (word_valid_i) st_d[bdm_pkg::ST_VALID] = 1'b1;
    if (entry_w) begin
      st_d[bdm_pkg::ST_ACTIVE] = 1'b1;
      st_d[bdm_pkg::ST_TAG]    = 1'b0;
    end
    if (lockout_w) st_d[bdm_pkg::ST_ACTIVE] = 1'b0;
  end

  // Status and lockout capture; mode-dependent reset value taken just after release
  // Capture on the third edge, once the mode synchroniser shows the pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q     <= bdm_pkg::ST_RST_OTHER;
      no_lockout_q <= 1'b1;
      init_q       <= 3'h0;
    end else if (!init_q[2]) begin
      init_q       <= {init_q[1:0], 1'b1};
      if (init_q[1]) begin
        no_lockout_q <= nvm_shadow_nolock_i;
        status_q     <= (special_w && (single_chip_i || peripheral_i) && nvm_shadow_nolock_i)
                        ? bdm_pkg::ST_RST_SPEC : bdm_pkg::ST_RST_OTHER;
      end
    end else begin
      status_q <= st_d;
      if (nolock_wr_i && special_w) no_lockout_q <= nolock_wdata_i;
    end
  end

  // Shifter, pointer and saved condition codes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_q <= 16'h0000;
      ptr_q   <= 16'h0000;
      ccr_q   <= 8'h00;
    end else begin
      if (word_valid_i) shift_q <= word_i;
      else if (wr_shi_w) shift_q[15:8] <= bus_i.wdata;
      else if (wr_slo_w) shift_q[7:0] <= bus_i.wdata;
      if (word_valid_i && addr_phase_i) ptr_q <= word_i;
      if (wr_ccr_w) ccr_q <= bus_i.wdata;
    end
  end

  // Register read selection, address decode as a chain
  logic [7:0] rd_sel_w;
  assign rd_sel_w = (bus_i.addr == bdm_pkg::ADDR_INSTR)    ? instr_q      :
                    (bus_i.addr == bdm_pkg::ADDR_STATUS)   ? status_q     :
                    (bus_i.addr == bdm_pkg::ADDR_SHIFT_HI) ? shift_q[15:8] :
                    (bus_i.addr == bdm_pkg::ADDR_SHIFT_LO) ? shift_q[7:0] :
                    (bus_i.addr == bdm_pkg::ADDR_PTR_HI)   ? ptr_q[15:8]  :
                    (bus_i.addr == bdm_pkg::ADDR_PTR_LO)   ? ptr_q[7:0]   :
                    ccr_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_q <= hit_any_w ? rd_sel_w : 8'h00;
    end
  end
  assign bus_rdata_o = rdata_q;

  // Read data handed back to the host is always a full word
  // Byte-named reads still return the whole shifter
  logic [15:0] read_word_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_word_q <= 16'h0000;
    end else if (instr_q[bdm_pkg::INS_RD]) begin
      read_word_q <= shift_q;
    end
  end
  assign read_word_o = read_word_q;

  // Clock selection; a slower E clock overrides the select bit
  assign use_e_clock_o = status_q[bdm_pkg::ST_CLKSEL] || e_slower_i;

  // Firmware decode and cycle stealing
  // Tagging holds serial opcodes back from the decoder
  fw_cmd_decoder u_dec (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .op_valid_i  (op_valid_i && !status_q[bdm_pkg::ST_TAG]),
    .op_i        (op_i),
    .active_i    (active_w),
    .cmd_valid_o (fw_cmd_valid_o),
    .cmd_o       (fw_cmd_o)
  );

  cycle_steal #(.WAIT_CYC(WAIT)) u_steal (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .req_i      (hw_req_i),
    .cpu_free_i (cpu_free_i),
    .multi_i    (multi_i),
    .done_i     (access_done_i),
    .grant_o    (grant_o),
    .freeze_o   (freeze_cpu_o)
  );

endmodule

// >>> verilog/bdm_pkg.sv
// Shared constants, types and register map of the background debug command unit
package bdm_pkg;

  // Debug register and ROM window
  localparam logic [15:0] ADDR_INSTR    = 16'hFF00;
  localparam logic [15:0] ADDR_STATUS   = 16'hFF01;
  localparam logic [15:0] ADDR_SHIFT_HI = 16'hFF02;
  localparam logic [15:0] ADDR_SHIFT_LO = 16'hFF03;
  localparam logic [15:0] ADDR_PTR_HI   = 16'hFF04;
  localparam logic [15:0] ADDR_PTR_LO   = 16'hFF05;
  localparam logic [15:0] ADDR_CCR      = 16'hFF06;
  localparam logic [15:0] ROM_LO        = 16'hFF20;
  localparam logic [15:0] ROM_HI        = 16'hFFFF;

  // Firmware opcodes
  localparam logic [7:0] OP_READ_NEXT  = 8'h62;
  localparam logic [7:0] OP_READ_SP    = 8'h67;
  localparam logic [7:0] OP_WRITE_NEXT = 8'h42;
  localparam logic [7:0] OP_WRITE_SP   = 8'h47;
  localparam logic [7:0] OP_GO         = 8'h08;
  localparam logic [7:0] OP_STEP       = 8'h10;
  localparam logic [7:0] OP_TAG_GO     = 8'h18;

  // Command register fields
  localparam int INS_HW  = 7;
  localparam int INS_RD  = 5;
  localparam int INS_MAP = 2;

  // Status register fields
  localparam int ST_PERMIT = 7;
  localparam int ST_ACTIVE = 6;
  localparam int ST_TAG    = 5;
  localparam int ST_VALID  = 4;
  localparam int ST_TRACE  = 3;
  localparam int ST_CLKSEL = 2;
  localparam logic [7:0] ST_WR_ALWAYS = 8'hB8;
  localparam logic [7:0] ST_RST_SPEC  = 8'h40;
  localparam logic [7:0] ST_RST_OTHER = 8'h00;

  // Cycle counts at the bus clock
  localparam int TIMEOUT_CYC   = 512;
  localparam int STEAL_WAIT    = 128;
  localparam int ACT_CLR_DELAY = 4;

  // Decoded firmware command
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       next;
    logic [2:0] reg_sel;
    logic       go;
    logic       step;
    logic       tag;
  } fw_cmd_s;

  // Byte access on the internal bus
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } bus_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_ACCESS} steal_e;

endpackage

// >>> verilog/fw_cmd_decoder.sv
// Firmware opcode decoder, gated by active background mode
`timescale 1ns/1ps
module fw_cmd_decoder (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  // Opcode from the shifter
  input  wire logic            op_valid_i,
  input  wire logic [7:0]      op_i,
  input  wire logic            active_i,
  // Decoded command
  output logic                 cmd_valid_o,
  output bdm_pkg::fw_cmd_s     cmd_o
);

  // Map one opcode onto its command fields; unknown codes give all zero
  function automatic bdm_pkg::fw_cmd_s decode(input logic [7:0] op);
    bdm_pkg::fw_cmd_s c;
    c = '0;
    if (op >= bdm_pkg::OP_READ_NEXT && op <= bdm_pkg::OP_READ_SP) begin
      c.rd      = 1'b1;
      c.next    = (op == bdm_pkg::OP_READ_NEXT);
      c.reg_sel = op[2:0];
    end else if (op >= bdm_pkg::OP_WRITE_NEXT && op <= bdm_pkg::OP_WRITE_SP) begin
      c.wr      = 1'b1;
      c.next    = (op == bdm_pkg::OP_WRITE_NEXT);
      c.reg_sel = op[2:0];
    end else begin
      c.go   = (op == bdm_pkg::OP_GO) || (op == bdm_pkg::OP_TAG_GO);
      c.step = (op == bdm_pkg::OP_STEP);
      c.tag  = (op == bdm_pkg::OP_TAG_GO);
    end
    return c;
  endfunction

  bdm_pkg::fw_cmd_s dec_w;
  logic             known_w;
  assign dec_w   = decode(op_i);
  assign known_w = |{dec_w.rd, dec_w.wr, dec_w.go, dec_w.step};

  // Only taken while the CPU sits in background mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
    end else begin
      cmd_valid_o <= op_valid_i && !op_i[bdm_pkg::INS_HW] && known_w && active_i;
      if (op_valid_i) cmd_o <= dec_w;
    end
  end

endmodule

// >>> verilog/cycle_steal.sv
// Free-cycle search and CPU freeze for hardware memory accesses
`timescale 1ns/1ps
module cycle_steal #(
  parameter int WAIT_CYC = bdm_pkg::STEAL_WAIT
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Access request and CPU bus state
  input  wire logic req_i,
  input  wire logic cpu_free_i,
  input  wire logic multi_i,
  input  wire logic done_i,
  // Grant and freeze
  output logic      grant_o,
  output logic      freeze_o
);

  bdm_pkg::steal_e state_q;
  logic [$clog2(WAIT_CYC+1)-1:0] wait_q;
  logic timeout_w;
  assign timeout_w = (wait_q == ($clog2(WAIT_CYC+1))'(WAIT_CYC));

  // Grant during the access; freeze the CPU once search times out or access is long
  assign grant_o  = (state_q == bdm_pkg::ST_ACCESS);
  assign freeze_o = (state_q == bdm_pkg::ST_ACCESS) && (multi_i || !cpu_free_i);

  // Search for a free bus cycle, then hold the buses until done
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= bdm_pkg::ST_IDLE;
      wait_q  <= '0;
    end else begin
      case (state_q)
        bdm_pkg::ST_IDLE: begin
          wait_q <= '0;
          if (req_i) state_q <= bdm_pkg::ST_SEARCH;
        end
        bdm_pkg::ST_SEARCH: begin
          wait_q <= wait_q + 1'b1;
          if (cpu_free_i || timeout_w) state_q <= bdm_pkg::ST_ACCESS;
        end
        default: begin
          if (done_i) state_q <= bdm_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bench/bdm_props.sv
// Port-level checks on the background debug command unit
`timescale 1ns/1ps
module bdm_props #(
  parameter int TIMEOUT = 512,
  parameter int WAIT    = 128
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // Watched inputs
  input wire logic              op_valid_i,
  input wire logic [7:0]        op_i,
  input wire logic              hw_req_i,
  input wire logic              access_done_i,
  input wire bdm_pkg::bus_req_s bus_i,
  input wire logic              bkgnd_req_i,
  input wire logic              e_slower_i,
  // Watched outputs
  input wire logic              grant_o,
  input wire logic              freeze_cpu_o,
  input wire logic              reg_hit_o,
  input wire logic              rom_select_o,
  input wire logic              background_debug_state_o,
  input wire logic              entry_refused_o,
  input wire logic              fw_cmd_valid_o,
  input wire logic              use_e_clock_o,
  input wire logic              lockout_o,
  input wire logic              reset_vector_block_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Steal handshake: a fresh request must be granted within 200 cycles
  sequence steal_req_s;
    $rose(hw_req_i) && !grant_o;
  endsequence
  sequence grant_seen_s;
    ##[1:200] grant_o;
  endsequence

  AST_STEAL_BOUND: assert property (steal_req_s |-> grant_seen_s)
    else $error("steal request not granted in time");
  AST_GRANT_HOLD: assert property (grant_o && !access_done_i |=> grant_o)
    else $error("buses released before access done");
  AST_FREEZE_GRANT: assert property (freeze_cpu_o |-> grant_o)
    else $error("CPU frozen without grant");
  AST_FW_ACTIVE: assert property (fw_cmd_valid_o |->
      $past(op_valid_i) && !$past(op_i[7]) && $past(background_debug_state_o))
    else $error("firmware command outside background mode");
  AST_ROM_RANGE: assert property (rom_select_o |-> bus_i.addr >= 16'hFF20 && !lockout_o)
    else $error("debug ROM selected outside its window");
  AST_REG_RANGE: assert property (reg_hit_o |-> bus_i.addr inside {[16'hFF00:16'hFF06]})
    else $error("debug register hit outside its window");
  AST_LOCK_IDLE: assert property (lockout_o |-> !background_debug_state_o)
    else $error("background mode active under lockout");
  AST_LOCK_REFUSE: assert property (lockout_o && bkgnd_req_i |-> entry_refused_o)
    else $error("entry not refused under lockout");
  AST_E_PHASE_CLOCK_FORCE: assert property (e_slower_i |-> use_e_clock_o)
    else $error("slow E clock not forced");
  AST_RSTVEC: assert property (reset_vector_block_o |-> lockout_o)
    else $error("reset vector blocked without lockout");
endmodule

bind background_debug_command_unit bdm_props #(.TIMEOUT(TIMEOUT), .WAIT(WAIT)) u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
  .hw_req_i(hw_req_i), .access_done_i(access_done_i), .bus_i(bus_i),
  .bkgnd_req_i(bkgnd_req_i), .e_slower_i(e_slower_i), .grant_o(grant_o),
  .freeze_cpu_o(freeze_cpu_o), .reg_hit_o(reg_hit_o), .rom_select_o(rom_select_o),
  .background_debug_state_o(background_debug_state_o),
  .entry_refused_o(entry_refused_o), .fw_cmd_valid_o(fw_cmd_valid_o),
  .use_e_clock_o(use_e_clock_o), .lockout_o(lockout_o),
  .reset_vector_block_o(reset_vector_block_o)
);

// >>> bench/debug_host_model.sv
// Behavioural debug host on the serial side of the command unit
`timescale 1ns/1ps
module debug_host_model (
  // Clock
  input  wire logic   clk_i,
  // Shifter hand-off toward the unit
  output logic        pin_o,
  output logic        op_valid_o,
  output logic [7:0]  op_o,
  output logic        word_valid_o,
  output logic [15:0] word_o,
  output logic        addr_phase_o
);
  // Pin idles high on its pull-up
  initial begin
    pin_o = 1'b1;
    op_valid_o = 1'b0;
    op_o = 8'h00;
    word_valid_o = 1'b0;
    word_o = 16'h0000;
    addr_phase_o = 1'b0;
  end

  // Host falling edge opens a frame and restarts the idle count
  task automatic frame();
    @(negedge clk_i);
    pin_o = 1'b0;
    @(negedge clk_i);
    pin_o = 1'b1;
  endtask

  // Opcode byte always leads a command; stale data is inverted, not held
  task automatic send_op(input logic [7:0] op);
    frame();
    op_o = op;
    op_valid_o = 1'b1;
    @(negedge clk_i);
    op_valid_o = 1'b0;
    op_o = ~op;
  endtask

  task automatic send_word(input logic [15:0] w, input logic adr);
    frame();
    word_o = w;
    addr_phase_o = adr;
    word_valid_o = 1'b1;
    @(negedge clk_i);
    word_valid_o = 1'b0;
    word_o = ~w;
  endtask

  // Host-side pacing after each firmware command
  task automatic pace(input logic [7:0] op);
    if (op[6] && !op[5]) begin
      send_word(16'hA55A, 1'b0);
      repeat (32) @(negedge clk_i);
    end else if (op[6]) begin
      repeat (32) @(negedge clk_i);
    end else begin
      repeat (64) @(negedge clk_i);
    end
  endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the background debug command unit
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int fw_seen = 0;
  int ref_seen = 0;
  logic ser, opv, wv, aph;
  logic [7:0] op;
  logic [15:0] wd;
  logic hw_req = 0, cpu_free = 0, multi = 0, done = 0, bkreq = 0;
  logic smode_n = 0, chip = 1, shadow = 1, nl_wr = 0, nl_d = 0, eslow = 0;
  bdm_pkg::bus_req_s bus = '0;
  bdm_pkg::fw_cmd_s fw, fw_last, fw_exp;
  logic grant, freeze, bds, refused, fwv, e_phase_clock, lock, rvb, rom, hit;
  logic [7:0] rdata;
  logic [15:0] rw;
  logic [7:0] ops [14] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h42,
                           8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h08, 8'h10};

  always #4 clk_i = ~clk_i;

  debug_host_model host (.clk_i(clk_i), .pin_o(ser), .op_valid_o(opv), .op_o(op),
    .word_valid_o(wv), .word_o(wd), .addr_phase_o(aph));

  background_debug_command_unit #(.TIMEOUT(16), .WAIT(8)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .debug_serial_pin_i(ser), .op_valid_i(opv),
    .op_i(op), .word_valid_i(wv), .word_i(wd), .addr_phase_i(aph), .hw_req_i(hw_req),
    .cpu_free_i(cpu_free), .multi_i(multi), .access_done_i(done), .grant_o(grant),
    .freeze_cpu_o(freeze), .bus_i(bus), .bus_rdata_o(rdata), .reg_hit_o(hit),
    .rom_select_o(rom), .bkgnd_req_i(bkreq), .instr_boundary_i(1'b1), .step_done_i(1'b0),
    .background_debug_state_o(bds), .entry_refused_o(refused), .fw_cmd_valid_o(fwv),
    .fw_cmd_o(fw), .read_word_o(rw), .special_mode_pin_n(smode_n), .single_chip_i(chip),
    .peripheral_i(1'b0), .nvm_shadow_nolock_i(shadow), .nolock_wr_i(nl_wr),
    .nolock_wdata_i(nl_d), .e_slower_i(eslow), .use_e_clock_o(e_phase_clock), .lockout_o(lock),
    .reset_vector_block_o(rvb));

  // Pulse monitors and hang guard; pulses last one or two cycles, so count them here
  always @(posedge clk_i) begin
    cyc++;
    if (fwv === 1'b1) begin
      fw_seen++;
      fw_last = fw;
    end
    if (refused === 1'b1) ref_seen++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Mode inputs must be settled before this is called
  task automatic do_reset();
    arst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(negedge clk_i);
    bus.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge clk_i);
    bus.rd = 1'b0;
    `CMP(rdata, e)
  endtask

  // Expected decode follows the command register bit fields
  task automatic fw_chk(input logic [7:0] o, input int n);
    fw_seen = 0;
    host.send_op(o);
    repeat (4) @(negedge clk_i);
    `CMP(fw_seen, n)
    fw_exp.rd = o[6] & o[5];
    fw_exp.wr = o[6] & ~o[5];
    fw_exp.next = o[6] & (o[2:0] == 3'h2);
    fw_exp.reg_sel = o[2:0];
    fw_exp.go = o[3];
    fw_exp.step = (o[4:3] == 2'h2);
    fw_exp.tag = (o[4:3] == 2'h3);
    if (n == 1) `CMP(fw_last, fw_exp)
    host.pace(o);
  endtask

  task automatic refuse_chk(input logic exp);
    ref_seen = 0;
    bkreq = 1'b1;
    repeat (2) @(negedge clk_i);
    bkreq = 1'b0;
    `CMP(ref_seen > 0, exp)
  endtask

  task automatic nl_set(input logic d);
    nl_d = d;
    nl_wr = 1'b1;
    @(negedge clk_i);
    nl_wr = 1'b0;
    @(negedge clk_i);
  endtask

  // Main sequence
  initial begin
    do_reset();
    rd_chk(16'hFF01, 8'h40);
    `CMP(bds, 1'b1)
    `CMP(lock, 1'b0)
    foreach (ops[i]) fw_chk(ops[i], 1);
    fw_chk(8'h60, 0);
    fw_chk(8'h90, 0);
    $display("test firmware done");
    host.frame();
    bus_wr(16'hFF00, 8'h80);
    bus_wr(16'hFF01, 8'h84);
    rd_chk(16'hFF01, 8'hC4);
    `CMP(e_phase_clock, 1'b1)
    repeat (24) @(negedge clk_i);
    rd_chk(16'hFF00, 8'h00);
    bus_wr(16'hFF06, 8'h5A);
    rd_chk(16'hFF06, 8'h5A);
    `CMP(hit, 1'b1)
    rd_chk(16'hFF10, 8'h00);
    $display("test registers done");
    // Multi-cycle access freezes the CPU, a single free cycle does not
    for (int m = 0; m < 2; m++) begin
      multi = m[0];
      cpu_free = ~m[0];
      hw_req = 1'b1;
      for (int k = 0; k < 20 && grant !== 1'b1; k++) @(negedge clk_i);
      `CMP(grant, 1'b1)
      `CMP(freeze, m[0])
      done = 1'b1;
      @(negedge clk_i);
      done = 1'b0;
      hw_req = 1'b0;
      @(negedge clk_i);
      `CMP(grant, 1'b0)
      repeat (150) @(negedge clk_i);
    end
    $display("test steal done");
    fw_chk(8'h18, 1);
    bus_wr(16'hFF01, 8'h80);
    repeat (2) @(negedge clk_i);
    `CMP(bds, 1'b1)
    repeat (3) @(negedge clk_i);
    `CMP(bds, 1'b0)
    rd_chk(16'hFF01, 8'h00);
    fw_chk(8'h63, 0);
    `CMP(rw, 16'hA55A)
    refuse_chk(1'b0);
    `CMP(bds, 1'b1)
    shadow = 1'b0; // shadow byte programmed to 7F
    do_reset();
    `CMP(lock, 1'b1)
    `CMP(bds, 1'b0)
    `CMP(rvb, 1'b1)
    rd_chk(16'hFFF0, 8'h00);
    `CMP(rom, 1'b0)
    refuse_chk(1'b1);
    nl_set(1'b1);
    `CMP(lock, 1'b0)
    shadow = 1'b1; // shadow byte erased
    do_reset();
    `CMP(bds, 1'b1)
    `CMP(rom, 1'b1)
    smode_n = 1'b1;
    do_reset();
    `CMP(bds, 1'b0)
    refuse_chk(1'b1);
    nl_set(1'b0);
    `CMP(lock, 1'b0)
    eslow = 1'b1;
    @(negedge clk_i);
    `CMP(e_phase_clock, 1'b1)
    $display("test lockout done");
    results();
  end
endmodule
